/* File: src/fpsc_cfg.svh */
`ifndef FPSC_CFG_SVH
`define FPSC_CFG_SVH
// ******************************
// Station address
// ******************************
`define FPSC_ADDR_MIN 7'h01
`define FPSC_ADDR_MAX 7'h7D
`define FPSC_ADDR_RST 7'h7E
// ******************************
// User parameter byte positions
// ******************************
`define FPSC_PRM_MIN_HI 4'h2
`define FPSC_PRM_MIN_LO 4'h3
`define FPSC_PRM_MAX_HI 4'h4
`define FPSC_PRM_MAX_LO 4'h5
`define FPSC_PRM_FS_CODE 4'h6
`define FPSC_PRM_FS_LO 4'h7
`define FPSC_PRM_FS_HI 4'h8
`define FPSC_PRM_LAST 4'h8
// ******************************
// Fail-safe codes
// ******************************
`define FPSC_FS_STOP 8'h00
`define FPSC_FS_HOLD 8'h01
`define FPSC_FS_SPEED 8'h02
// ******************************
// Speeds and timing
// ******************************
`define FPSC_SPEED_FULL 16'hFFFF
`define FPSC_SPEED_RST 16'h0000
`define FPSC_MENU_TIMEOUT_MIN 5
`define FPSC_CLK_MHZ 250
`define FPSC_MENU_TIMEOUT_CYC (64'd60000000 * `FPSC_MENU_TIMEOUT_MIN * `FPSC_CLK_MHZ)
`define FPSC_SCROLL_CYC 32'd62500000
`endif

/* File: src/fpsc_pkg.sv */
package fpsc_pkg;
   typedef enum logic [1:0] {
      FPSC_STOPPED = 2'b00,
      FPSC_RUNNING = 2'b01,
      FPSC_FULLFLOW = 2'b11
   } fpsc_run_e;
endpackage

/* File: src/fpsc_top.sv */
`timescale 1ns/10ps
`include "fpsc_cfg.svh"
module fpsc_top #(
   parameter int WIDTH = 16,
   parameter longint MENU_TIMEOUT_CYC = `FPSC_MENU_TIMEOUT_CYC,
   parameter int SCROLL_CYC = `FPSC_SCROLL_CYC
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_key_start,
   input wire logic i_key_stop,
   input wire logic i_key_inc,
   input wire logic i_key_dec,
   input wire logic i_key_full,
   input wire logic i_key_addr_inc,
   input wire logic i_key_addr_dec,
   input wire logic i_key_any,
   input wire logic i_manual_mode,
   input wire logic i_fieldbus_mode,
   input wire logic i_analog_mode,
   input wire logic i_in_menu,
   input wire logic i_ext_run,
   input wire logic i_auto_restart,
   input wire logic [1:0] i_saved_state,
   input wire logic [WIDTH-1:0] i_saved_speed,
   input wire logic i_bus_enable,
   input wire logic i_bus_set_addr,
   input wire logic [6:0] i_bus_addr,
   input wire logic i_bus_xchg,
   input wire logic i_prm_we,
   input wire logic [3:0] i_prm_idx,
   input wire logic [7:0] i_prm_data,
   input wire logic [15:0] i_bus_ctrl,
   input wire logic [WIDTH-1:0] i_bus_speed,
   output logic [WIDTH-1:0] o_drive_speed,
   output logic o_motor_on,
   output logic [WIDTH-1:0] o_setpoint,
   output logic [31:0] o_full_volume,
   output logic [31:0] o_full_time,
   output logic o_remote_warn,
   output logic [6:0] o_station_addr,
   output logic o_xchg_active,
   output logic o_comm_lost,
   output logic o_bus_error,
   output logic o_menu_home
);
   // ******************************
   // Power-on restore
   // ******************************
   logic boot_q;
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         boot_q <= 1'b1;
      end else begin
         boot_q <= 1'b0;
      end
   end

   // ******************************
   // Local run state
   // ******************************
   fpsc_pkg::fpsc_run_e run_q;
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         run_q <= fpsc_pkg::FPSC_STOPPED;
      end else if (boot_q) begin
         if (i_auto_restart && i_saved_state == 2'b01) begin
            run_q <= fpsc_pkg::FPSC_RUNNING;
         end else begin
            run_q <= fpsc_pkg::FPSC_STOPPED;
         end
      end else begin
         case (run_q)
            fpsc_pkg::FPSC_STOPPED: begin
               // Full-flow ignores the external start/stop input
               if (i_manual_mode && i_key_full) begin
                  run_q <= fpsc_pkg::FPSC_FULLFLOW;
               end else if (i_manual_mode && i_key_start && !i_key_stop) begin
                  run_q <= fpsc_pkg::FPSC_RUNNING;
               end
            end
            fpsc_pkg::FPSC_RUNNING: begin
               if (i_key_stop || !i_manual_mode) begin
                  run_q <= fpsc_pkg::FPSC_STOPPED;
               end
            end
            fpsc_pkg::FPSC_FULLFLOW: begin
               if (!i_key_full || i_key_stop || !i_manual_mode) begin
                  run_q <= fpsc_pkg::FPSC_STOPPED;
               end
            end
            default: begin
               run_q <= fpsc_pkg::FPSC_STOPPED;
            end
         endcase
      end
   end

   // ******************************
   // Setpoint stepping and scroll
   // ******************************
   logic inc_d1_q;
   logic dec_d1_q;
   logic [31:0] scroll_cnt_q;
   logic step_inc;
   logic step_dec;
   logic scroll_tick;
   assign scroll_tick = (scroll_cnt_q == 32'(SCROLL_CYC - 1));
   assign step_inc = i_key_inc && !i_key_dec && (!inc_d1_q || scroll_tick);
   assign step_dec = i_key_dec && !i_key_inc && (!dec_d1_q || scroll_tick);

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         inc_d1_q <= 1'b0;
         dec_d1_q <= 1'b0;
         scroll_cnt_q <= 32'h00000000;
      end else begin
         inc_d1_q <= i_key_inc;
         dec_d1_q <= i_key_dec;
         if (!(i_key_inc ^ i_key_dec) || scroll_tick || (i_key_inc && !inc_d1_q) || (i_key_dec && !dec_d1_q)) begin
            scroll_cnt_q <= 32'h00000000;
         end else begin
            scroll_cnt_q <= scroll_cnt_q + 32'h00000001;
         end
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_setpoint <= WIDTH'(`FPSC_SPEED_RST);
      end else if (boot_q && i_auto_restart) begin
         o_setpoint <= i_saved_speed;
      end else if (step_inc && o_setpoint != {WIDTH{1'b1}}) begin
         o_setpoint <= o_setpoint + WIDTH'(1);
      end else if (step_dec && o_setpoint != '0) begin
         o_setpoint <= o_setpoint - WIDTH'(1);
      end
   end

   // ******************************
   // Full-flow accumulators
   // ******************************
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_full_volume <= 32'h00000000;
         o_full_time <= 32'h00000000;
      end else if (run_q == fpsc_pkg::FPSC_FULLFLOW) begin
         // Volume in drive-speed units per cycle; scaling is left to the display
         o_full_volume <= o_full_volume + 32'(`FPSC_SPEED_FULL);
         o_full_time <= o_full_time + 32'h00000001;
      end else if (i_manual_mode && i_key_full) begin
         o_full_volume <= 32'h00000000;
         o_full_time <= 32'h00000000;
      end
   end

   // ******************************
   // Station address and bus enable
   // ******************************
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_station_addr <= `FPSC_ADDR_RST;
      end else if (i_in_menu && i_key_addr_inc) begin
         // i_bus_set_addr and i_bus_addr are deliberately unused
         if (o_station_addr >= `FPSC_ADDR_MAX) begin
            o_station_addr <= `FPSC_ADDR_MIN;
         end else begin
            o_station_addr <= o_station_addr + 7'h01;
         end
      end else if (i_in_menu && i_key_addr_dec) begin
         if (o_station_addr <= `FPSC_ADDR_MIN || o_station_addr > `FPSC_ADDR_MAX) begin
            o_station_addr <= `FPSC_ADDR_MAX;
         end else begin
            o_station_addr <= o_station_addr - 7'h01;
         end
      end
   end

   logic xchg;
   assign xchg = i_fieldbus_mode && i_bus_enable && i_bus_xchg;
   logic xchg_seen_q;
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_xchg_active <= 1'b0;
         o_comm_lost <= 1'b0;
         xchg_seen_q <= 1'b0;
      end else begin
         o_xchg_active <= xchg;
         if (xchg) begin
            xchg_seen_q <= 1'b1;
            o_comm_lost <= 1'b0;
         end else if (xchg_seen_q && i_fieldbus_mode && i_bus_enable) begin
            o_comm_lost <= 1'b1;
         end else if (!i_fieldbus_mode || !i_bus_enable) begin
            xchg_seen_q <= 1'b0;
            o_comm_lost <= 1'b0;
         end
      end
   end

   // ******************************
   // User parameters
   // ******************************
   logic [15:0] min_q;
   logic [15:0] max_q;
   logic [15:0] fs_speed_q;
   logic [7:0] fs_code_q;
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         min_q <= 16'h0000;
         max_q <= 16'h0000;
         fs_speed_q <= 16'h0000;
         fs_code_q <= `FPSC_FS_STOP;
      end else if (i_prm_we && i_prm_idx <= `FPSC_PRM_LAST) begin
         case (i_prm_idx)
            `FPSC_PRM_MIN_HI: min_q[15:8] <= i_prm_data;
            `FPSC_PRM_MIN_LO: min_q[7:0] <= i_prm_data;
            `FPSC_PRM_MAX_HI: max_q[15:8] <= i_prm_data;
            `FPSC_PRM_MAX_LO: max_q[7:0] <= i_prm_data;
            `FPSC_PRM_FS_CODE: fs_code_q <= i_prm_data;
            `FPSC_PRM_FS_LO: fs_speed_q[7:0] <= i_prm_data;
            `FPSC_PRM_FS_HI: fs_speed_q[15:8] <= i_prm_data;
            default: begin
            end
         endcase
      end
   end

   // ******************************
   // Bus speed clamp and fail-safe
   // ******************************
   logic [WIDTH-1:0] clamp_min;
   logic [WIDTH-1:0] clamp_out;
   logic lim_on;
   assign lim_on = i_bus_ctrl[4];
   always_comb begin
      clamp_min = i_bus_speed;
      if (lim_on && min_q != 16'h0000 && i_bus_speed < WIDTH'(min_q)) begin
         clamp_min = WIDTH'(min_q);
      end
      clamp_out = clamp_min;
      if (lim_on && max_q != 16'h0000 && clamp_min > WIDTH'(max_q)) begin
         clamp_out = WIDTH'(max_q);
      end
   end

   logic [WIDTH-1:0] last_bus_q;
   logic bus_run_q;
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         last_bus_q <= WIDTH'(`FPSC_SPEED_RST);
         bus_run_q <= 1'b0;
      end else if (xchg) begin
         last_bus_q <= clamp_out;
         bus_run_q <= i_bus_ctrl[0];
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_drive_speed <= WIDTH'(`FPSC_SPEED_RST);
         o_motor_on <= 1'b0;
      end else if (i_fieldbus_mode && i_bus_enable) begin
         if (!o_comm_lost) begin
            o_drive_speed <= last_bus_q;
            o_motor_on <= bus_run_q;
         end else if (fs_code_q == `FPSC_FS_HOLD) begin
            o_drive_speed <= last_bus_q;
            o_motor_on <= bus_run_q;
         end else if (fs_code_q == `FPSC_FS_SPEED) begin
            o_drive_speed <= WIDTH'(fs_speed_q);
            o_motor_on <= 1'b1;
         end else begin
            o_drive_speed <= WIDTH'(`FPSC_SPEED_RST);
            o_motor_on <= 1'b0;
         end
      end else if (run_q == fpsc_pkg::FPSC_FULLFLOW) begin
         o_drive_speed <= WIDTH'(`FPSC_SPEED_FULL);
         o_motor_on <= 1'b1;
      end else if (run_q == fpsc_pkg::FPSC_RUNNING) begin
         o_drive_speed <= o_setpoint;
         o_motor_on <= 1'b1;
      end else begin
         o_drive_speed <= WIDTH'(`FPSC_SPEED_RST);
         o_motor_on <= 1'b0;
      end
   end

   // ******************************
   // Warning and menu timeout
   // ******************************
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_remote_warn <= 1'b0;
      end else begin
         o_remote_warn <= i_analog_mode || i_fieldbus_mode || i_auto_restart;
      end
   end

   logic [63:0] idle_q;
   logic menu_tmo;
   assign menu_tmo = (idle_q == 64'(MENU_TIMEOUT_CYC - 1));
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         idle_q <= 64'h0;
         o_menu_home <= 1'b0;
         o_bus_error <= 1'b0;
      end else begin
         o_menu_home <= 1'b0;
         if (!(i_fieldbus_mode && i_in_menu) || i_key_any) begin
            idle_q <= 64'h0;
         end else if (menu_tmo) begin
            idle_q <= 64'h0;
            o_menu_home <= 1'b1;
            o_bus_error <= !xchg;
         end else begin
            idle_q <= idle_q + 64'h1;
         end
         if (xchg) begin
            o_bus_error <= 1'b0;
         end
      end
   end

   // ******************************
   // Checks
   // ******************************
   property p_start;
      @(posedge i_mclk) disable iff (i_rst)
      (run_q == fpsc_pkg::FPSC_STOPPED && !boot_q && i_manual_mode && i_key_start && !i_key_stop && !i_key_full)
      |=> run_q == fpsc_pkg::FPSC_RUNNING;
   endproperty
   a_start: assert property (p_start) else $error("start not taken");

   property p_stop;
      @(posedge i_mclk) disable iff (i_rst)
      (run_q == fpsc_pkg::FPSC_RUNNING && !boot_q && i_key_stop) |=> run_q == fpsc_pkg::FPSC_STOPPED;
   endproperty
   a_stop: assert property (p_stop) else $error("stop not taken");

   property p_inc;
      @(posedge i_mclk) disable iff (i_rst)
      (!boot_q && i_key_inc && !inc_d1_q && !i_key_dec && o_setpoint != {WIDTH{1'b1}})
      |=> o_setpoint == $past(o_setpoint) + WIDTH'(1);
   endproperty
   a_inc: assert property (p_inc) else $error("increase step wrong");

   property p_dec;
      @(posedge i_mclk) disable iff (i_rst)
      (!boot_q && i_key_dec && !dec_d1_q && !i_key_inc && o_setpoint != '0)
      |=> o_setpoint == $past(o_setpoint) - WIDTH'(1);
   endproperty
   a_dec: assert property (p_dec) else $error("decrease step wrong");

   property p_full;
      @(posedge i_mclk) disable iff (i_rst)
      (run_q == fpsc_pkg::FPSC_FULLFLOW && !(i_fieldbus_mode && i_bus_enable))
      |=> o_drive_speed == WIDTH'(`FPSC_SPEED_FULL) && o_motor_on;
   endproperty
   a_full: assert property (p_full) else $error("full flow not driven");

   property p_addr;
      @(posedge i_mclk) disable iff (i_rst)
      $changed(o_station_addr) |-> o_station_addr >= `FPSC_ADDR_MIN && o_station_addr <= `FPSC_ADDR_MAX;
   endproperty
   a_addr: assert property (p_addr) else $error("address out of range");

   property p_xchg;
      @(posedge i_mclk) disable iff (i_rst)
      o_xchg_active |-> $past(i_bus_enable) && $past(i_fieldbus_mode);
   endproperty
   a_xchg: assert property (p_xchg) else $error("exchange flagged while disabled");

   property p_fs_stop;
      @(posedge i_mclk) disable iff (i_rst)
      (o_comm_lost && i_fieldbus_mode && i_bus_enable && fs_code_q != `FPSC_FS_HOLD && fs_code_q != `FPSC_FS_SPEED)
      |=> !o_motor_on;
   endproperty
   a_fs_stop: assert property (p_fs_stop) else $error("fail-safe stop missed");

   property p_fs_speed;
      @(posedge i_mclk) disable iff (i_rst)
      (o_comm_lost && i_fieldbus_mode && i_bus_enable && fs_code_q == `FPSC_FS_SPEED)
      |=> o_drive_speed == WIDTH'($past(fs_speed_q));
   endproperty
   a_fs_speed: assert property (p_fs_speed) else $error("fail-safe speed missed");

   property p_max;
      @(posedge i_mclk) disable iff (i_rst)
      (lim_on && max_q != 16'h0000) |-> clamp_out <= WIDTH'(max_q);
   endproperty
   a_max: assert property (p_max) else $error("max clamp broken");
endmodule

/* File: verification/fpsc_bus_model.sv */
`timescale 1ns/10ps
// ******************************
// Fieldbus master model
// ******************************
module fpsc_bus_model (
   input wire logic i_mclk,
   output logic o_xchg,
   output logic o_prm_we,
   output logic [3:0] o_prm_idx,
   output logic [7:0] o_prm_data,
   output logic [15:0] o_ctrl,
   output logic [15:0] o_speed,
   output logic o_set_addr,
   output logic [6:0] o_addr
);
   initial begin
      o_xchg = 1'b0;
      o_prm_we = 1'b0;
      o_prm_idx = 4'h0;
      o_prm_data = 8'h00;
      o_ctrl = 16'h0000;
      o_speed = 16'h0000;
      o_set_addr = 1'b0;
      o_addr = 7'h00;
   end

   // Never more than nine bytes in one parameterisation
   task automatic load_prm(input logic [15:0] mn, input logic [15:0] mx, input logic [7:0] code,
                           input logic [15:0] fs);
      logic [7:0] b [9];
      b = '{8'h00, 8'h00, mn[15:8], mn[7:0], mx[15:8], mx[7:0], code, fs[7:0], fs[15:8]};
      for (int i = 0; i < 9; i++) begin
         @(negedge i_mclk);
         o_prm_we = 1'b1;
         o_prm_idx = i[3:0];
         o_prm_data = b[i];
      end
      @(negedge i_mclk);
      o_prm_we = 1'b0;
      // Released data lines must not keep the last byte
      o_prm_data = ~o_prm_data;
   endtask

   task automatic cyclic(input logic run, input logic lim, input logic [15:0] spd);
      @(negedge i_mclk);
      o_ctrl = {11'h000, lim, 3'h0, run};
      o_speed = spd;
   endtask

   task automatic exchange(input logic on);
      @(negedge i_mclk);
      o_xchg = on;
   endtask

   task automatic try_addr(input logic [6:0] a);
      @(negedge i_mclk);
      o_set_addr = 1'b1;
      o_addr = a;
      @(negedge i_mclk);
      o_set_addr = 1'b0;
      o_addr = ~a;
   endtask
endmodule

/* File: verification/tb.sv */
`timescale 1ns/10ps
module tb;
   logic i_mclk = 1'b0, i_rst = 1'b1;
   logic k_start = 1'b0, k_stop = 1'b0, k_inc = 1'b0, k_dec = 1'b0, k_full = 1'b0;
   logic k_ainc = 1'b0, k_adec = 1'b0, k_any = 1'b0;
   logic man = 1'b1, fbm = 1'b0, ana = 1'b0, menu = 1'b0, ext_run = 1'b0, auto_rs = 1'b0, bus_en = 1'b0;
   logic [1:0] sv_state = 2'b00;
   logic [15:0] sv_speed = 16'h0000;
   logic xchg, prm_we, set_addr;
   logic [3:0] prm_idx;
   logic [7:0] prm_data;
   logic [15:0] ctrl, spd, drv, setp;
   logic [6:0] baddr, station;
   logic [31:0] vol, tim;
   logic mon, warn, xact, lost, berr, home;
   int errors = 0;
   int total_checks = 0;

   always #2 i_mclk = ~i_mclk;

   fpsc_bus_model i_mst (.i_mclk(i_mclk), .o_xchg(xchg), .o_prm_we(prm_we), .o_prm_idx(prm_idx),
      .o_prm_data(prm_data), .o_ctrl(ctrl), .o_speed(spd), .o_set_addr(set_addr), .o_addr(baddr));

   fpsc_top #(.MENU_TIMEOUT_CYC(50), .SCROLL_CYC(4)) i_dut (.i_mclk(i_mclk), .i_rst(i_rst),
      .i_key_start(k_start), .i_key_stop(k_stop), .i_key_inc(k_inc), .i_key_dec(k_dec), .i_key_full(k_full),
      .i_key_addr_inc(k_ainc), .i_key_addr_dec(k_adec), .i_key_any(k_any), .i_manual_mode(man),
      .i_fieldbus_mode(fbm), .i_analog_mode(ana), .i_in_menu(menu), .i_ext_run(ext_run),
      .i_auto_restart(auto_rs), .i_saved_state(sv_state), .i_saved_speed(sv_speed), .i_bus_enable(bus_en),
      .i_bus_set_addr(set_addr), .i_bus_addr(baddr), .i_bus_xchg(xchg), .i_prm_we(prm_we),
      .i_prm_idx(prm_idx), .i_prm_data(prm_data), .i_bus_ctrl(ctrl), .i_bus_speed(spd),
      .o_drive_speed(drv), .o_motor_on(mon), .o_setpoint(setp), .o_full_volume(vol), .o_full_time(tim),
      .o_remote_warn(warn), .o_station_addr(station), .o_xchg_active(xact), .o_comm_lost(lost),
      .o_bus_error(berr), .o_menu_home(home));

   task automatic cyc(input int n);
      repeat (n) @(negedge i_mclk);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic close_out;
      $display("Checks %0d, mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Keys driven by name so every key input is a real bench variable
   task automatic set_key(input int sel, input logic v);
      case (sel)
         0: k_start = v;
         1: k_stop = v;
         2: k_inc = v;
         3: k_dec = v;
         4: k_ainc = v;
         default: k_adec = v;
      endcase
   endtask

   // Key held for exactly one sampling edge
   task automatic press(input int sel);
      set_key(sel, 1'b1);
      cyc(1);
      set_key(sel, 1'b0);
      cyc(3);
   endtask

   task automatic do_reset;
      i_rst = 1'b1;
      cyc(20);
      i_rst = 1'b0;
      cyc(2);
   endtask

   task automatic t_reset;
      chk(station, 7'h7E);
      chk(mon, 1'b0);
      chk(drv, 16'h0000);
      $display("test reset done");
   endtask

   task automatic t_manual;
      repeat (3) press(2);
      chk(setp, 16'h0003);
      press(3);
      chk(setp, 16'h0002);
      press(0);
      chk(mon, 1'b1);
      chk(drv, 16'h0002);
      press(0);
      chk(mon, 1'b1);
      chk(drv, 16'h0002);
      press(1);
      chk(mon, 1'b0);
      press(1);
      chk(mon, 1'b0);
      chk(drv, 16'h0000);
      $display("test manual done");
   endtask

   task automatic t_scroll;
      logic [15:0] s0;
      s0 = setp;
      k_inc = 1'b1;
      cyc(10);
      k_inc = 1'b0;
      cyc(2);
      chk((setp - s0) >= 2 && (setp - s0) <= 4, 1'b1);
      s0 = setp;
      cyc(8);
      chk(setp, s0);
      k_inc = 1'b1;
      k_dec = 1'b1;
      cyc(10);
      k_inc = 1'b0;
      k_dec = 1'b0;
      cyc(2);
      chk(setp, s0);
      $display("test scroll done");
   endtask

   task automatic t_full;
      ext_run = 1'b0;
      k_full = 1'b1;
      cyc(6);
      chk(mon, 1'b1);
      chk(drv, 16'hFFFF);
      chk(vol != 0, 1'b1);
      chk(tim != 0, 1'b1);
      k_full = 1'b0;
      ext_run = 1'b1;
      cyc(3);
      chk(mon, 1'b0);
      $display("test full flow done");
   endtask

   task automatic t_warn;
      logic [2:0] m [4] = '{3'b000, 3'b100, 3'b010, 3'b001};
      man = 1'b1;
      for (int i = 0; i < 4; i++) begin
         fbm = m[i][2];
         ana = m[i][1];
         auto_rs = m[i][0];
         cyc(3);
         chk(warn, i != 0);
      end
      fbm = 1'b0;
      ana = 1'b0;
      auto_rs = 1'b0;
      $display("test warning done");
   endtask

   task automatic t_addr;
      man = 1'b0;
      fbm = 1'b1;
      menu = 1'b1;
      k_any = 1'b1;
      press(4);
      chk(station, 7'h01);
      press(5);
      chk(station, 7'h7D);
      i_mst.try_addr(7'h05);
      cyc(3);
      chk(station, 7'h7D);
      menu = 1'b0;
      k_any = 1'b0;
      $display("test address done");
   endtask

   task automatic t_bus;
      bus_en = 1'b0;
      i_mst.load_prm(16'd100, 16'd200, 8'h00, 16'd180);
      i_mst.cyclic(1'b1, 1'b1, 16'd150);
      i_mst.exchange(1'b1);
      cyc(4);
      chk(xact, 1'b0);
      bus_en = 1'b1;
      cyc(4);
      chk(xact, 1'b1);
      chk(drv, 16'd150);
      i_mst.cyclic(1'b1, 1'b1, 16'd50);
      cyc(4);
      chk(drv, 16'd100);
      i_mst.cyclic(1'b1, 1'b1, 16'd300);
      cyc(4);
      chk(drv, 16'd200);
      i_mst.cyclic(1'b1, 1'b0, 16'd300);
      cyc(4);
      chk(drv, 16'd300);
      i_mst.load_prm(16'd0, 16'd200, 8'h00, 16'd180);
      i_mst.cyclic(1'b1, 1'b1, 16'd50);
      cyc(4);
      chk(drv, 16'd50);
      $display("test bus limits done");
   endtask

   task automatic t_failsafe;
      logic [7:0] code [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h80};
      logic [15:0] ed [5] = '{16'd0, 16'd150, 16'd180, 16'd0, 16'd0};
      for (int i = 0; i < 5; i++) begin
         i_mst.load_prm(16'd100, 16'd200, code[i], 16'd180);
         i_mst.cyclic(1'b1, 1'b1, 16'd150);
         i_mst.exchange(1'b1);
         cyc(4);
         chk(drv, 16'd150);
         i_mst.exchange(1'b0);
         cyc(4);
         chk(lost, 1'b1);
         chk(drv, ed[i]);
         chk(mon, ed[i] != 0);
         cyc(6);
         chk(drv, ed[i]);
      end
      i_mst.exchange(1'b1);
      cyc(4);
      chk(lost, 1'b0);
      $display("test fail-safe done");
   endtask

   task automatic t_menu;
      int n;
      i_mst.exchange(1'b0);
      menu = 1'b1;
      n = 0;
      while (home !== 1'b1 && n < 200) begin
         cyc(1);
         n++;
      end
      if (n >= 200) begin
         errors++;
         close_out();
      end
      chk(n >= 45, 1'b1);
      cyc(2);
      chk(berr, 1'b1);
      menu = 1'b0;
      i_mst.exchange(1'b1);
      cyc(4);
      chk(berr, 1'b0);
      $display("test menu timeout done");
   endtask

   task automatic t_restart;
      fbm = 1'b0;
      bus_en = 1'b0;
      man = 1'b1;
      auto_rs = 1'b1;
      sv_state = 2'b01;
      sv_speed = 16'h0123;
      do_reset();
      cyc(2);
      chk(mon, 1'b1);
      chk(drv, 16'h0123);
      chk(warn, 1'b1);
      auto_rs = 1'b0;
      do_reset();
      cyc(2);
      chk(mon, 1'b0);
      $display("test restart done");
   endtask

   initial begin
      do_reset();
      t_reset();
      t_manual();
      t_scroll();
      t_full();
      t_warn();
      t_addr();
      t_bus();
      t_failsafe();
      t_menu();
      t_restart();
      close_out();
   end
endmodule
